// ===== mfm_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the motion fault monitor.
// Assumes: Byte addresses on a 32-bit register port, one aligned word per register.
// Notes: The fault codes are the numbers the controller shows in its fault code monitor.
`ifndef MFM_DEFS_SVH
`define MFM_DEFS_SVH

`define MFM_A_CTRL 8'h00
`define MFM_A_CODE 8'h04
`define MFM_A_STAT 8'h08
`define MFM_A_IEN 8'h0C
`define MFM_A_ICLR 8'h10
`define MFM_A_CHKA 8'h14
`define MFM_A_CHKB 8'h18
`define MFM_A_MOPT 8'h1C
`define MFM_A_ROLE 8'h20
`define MFM_A_LEAVE 8'h24
`define MFM_A_ENDA 8'h28
`define MFM_A_ENDB 8'h2C
`define MFM_A_STLO 8'h30
`define MFM_A_STHI 8'h34
`define MFM_A_STCHK 8'h38
`define MFM_A_SYNC 8'h3C
`define MFM_A_HSEL 8'h40
`define MFM_A_HDAT 8'h44

`define MFM_B_SWRST 0
`define MFM_B_CHAIN_TMO 1
`define MFM_B_STROKE_ACT 1
`define MFM_B_STROKE_REF 2
`define MFM_B_LATCHED 8
`define MFM_B_HWONLY 9

`define MFM_SEQ_LINE_MAX 16'h1FFE
`define MFM_STACK_MAX 9'h100
`define MFM_CHKA_MAX 32'h0000_00FF
`define MFM_CHKB_MAX 32'h0000_00FF
`define MFM_ROLE_MASTER 32'h0000_0001
`define MFM_RST_ZERO 32'h0000_0000
`define MFM_HW_ONLY_MASK 16'h011C

`define MFM_CLK_MHZ 40
`define MFM_CHAIN_TMO_US 100
`define MFM_CHAIN_TMO_CYC (`MFM_CHAIN_TMO_US * `MFM_CLK_MHZ)

`endif

// ===== mfm_pkg.sv
// Purpose: Types shared by the motion fault monitor files.
// Assumes: Constants live in the defs header.
// Notes: Event indices follow the order of the fault codes.
package mfm_pkg;

  // Register port request bundle.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mfm_bus_req_t;

  // Homing run kind.
  typedef enum logic [1:0] {
    MFM_HOME_IDLE = 2'b00,
    MFM_HOME_MULTI = 2'b01,
    MFM_HOME_SINGLE = 2'b10
  } mfm_home_t;

endpackage

// ===== mfm_hist_mem.sv
// Purpose: Small history memory of latched fault codes.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data come out of a register one cycle after the address.
`timescale 1ns/1ps
module mfm_hist_mem (
  input wire logic clock_in,
  input wire logic ce_in,
  input wire logic wr_in,
  input wire logic [3:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [3:0] raddr_in,
  output logic [7:0] rdata_out
);

  logic [7:0] mem_q [0:15];

  // Write a code and read the selected entry into the output register.
  always_ff @(posedge clock_in) begin
    if (ce_in) begin
      if (wr_in) begin
        mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_q[raddr_in];
    end
  end

endmodule

// ===== mfm_monitor.sv
// Purpose: Fault detection and reporting unit for fault codes 37 to 66 of a position controller.
// Assumes: One 40 MHz clock; all inputs but the chain command pin come from logic on that clock.
// Notes: The first fault latched holds; a hardware-reset-only fault may replace a software-clearable one.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`include "mfm_defs.svh"
`timescale 1ns/1ps
module mfm_monitor
  import mfm_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out,
  output logic [7:0] fault_code_out,
  output logic fault_active_out,
  input wire logic seq_exec_in,
  input wire logic [15:0] seq_line_in,
  input wire logic reg_access_in,
  input wire logic [15:0] reg_index_in,
  input wire logic [15:0] reg_index_max_in,
  input wire logic stack_push_in,
  input wire logic stack_pop_in,
  input wire logic axis_cmd_in,
  input wire logic [3:0] axis_num_in,
  input wire logic [15:0] axis_present_in,
  input wire logic chain_init_fail_in,
  input wire logic chain_cmd_pin_in,
  input wire logic chain_dup_node_in,
  input wire logic [1:0] homing_mode_in,
  input wire logic homing_done_in,
  input wire logic [31:0] leave_travel_in,
  input wire logic switch_active_in,
  input wire logic sync_start_fail_in,
  input wire logic [31:0] actual_position_in,
  input wire logic [31:0] ref_position_in
);

  mfm_bus_req_t req;
  mfm_home_t home_mode;
  logic [31:0] chk_a_q, chk_b_q, mon_opt_q, role_q, leave_q, end_a_q, end_b_q;
  logic [31:0] st_lo_q, st_hi_q, st_chk_q, sync_q;
  logic [3:0] hist_sel_q, hist_wp_q;
  logic [15:0] status_q, irq_en_q, ev;
  logic [8:0] depth_q;
  logic [7:0] code_q, hist_rd;
  logic latched_q, hw_q, sw_rst;
  logic sync1_q, sync2_q, sync3_q, cmd_lvl_q, cmd_seen, chain_armed_q;
  logic [12:0] tmo_cnt_q;
  logic hit_a_q, hit_b_q, load;
  logic [3:0] pick;
  logic [31:0] rdata_q;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign home_mode = mfm_home_t'(homing_mode_in);

  // Maps an event index onto its fault code.
  function automatic logic [7:0] code_of(input logic [3:0] idx);
    case (idx)
      4'h0: code_of = 8'h25;
      4'h1: code_of = 8'h26;
      4'h2: code_of = 8'h27;
      4'h3: code_of = 8'h28;
      4'h4: code_of = 8'h29;
      4'h5: code_of = 8'h34;
      4'h6: code_of = 8'h36;
      4'h7: code_of = 8'h38;
      4'h8: code_of = 8'h3B;
      4'h9: code_of = 8'h3C;
      4'hA: code_of = 8'h3D;
      4'hB: code_of = 8'h3E;
      4'hC: code_of = 8'h3F;
      4'hD: code_of = 8'h41;
      4'hE: code_of = 8'h42;
      default: code_of = 8'h00;
    endcase
  endfunction

  // True when the fault of an event index may only be cleared by a hardware reset.
  function automatic logic hw_only(input logic [3:0] idx);
    logic [15:0] mask;
    mask = `MFM_HW_ONLY_MASK;
    hw_only = mask[idx];
  endfunction

  // True when a signed position lies outside the stroke window.
  function automatic logic out_of(input logic [31:0] p, input logic [31:0] lo, input logic [31:0] hi);
    out_of = ($signed(p) < $signed(lo)) || ($signed(p) > $signed(hi));
  endfunction

  // Three-stage synchroniser on the chain command pin; a change counts when stages two and three agree.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      cmd_lvl_q <= 1'b0;
    end else if (ce_in) begin
      sync1_q <= chain_cmd_pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        cmd_lvl_q <= sync3_q;
      end
    end
  end
  assign cmd_seen = (sync2_q == sync3_q) && (sync3_q != cmd_lvl_q);

  // Command timeout counter, armed by the first command and restarted by each one.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      chain_armed_q <= 1'b0;
      tmo_cnt_q <= 13'h0000;
    end else if (ce_in) begin
      if (cmd_seen) begin
        chain_armed_q <= 1'b1;
        tmo_cnt_q <= 13'h0000;
      end else if (chain_armed_q && tmo_cnt_q != 13'(`MFM_CHAIN_TMO_CYC)) begin
        tmo_cnt_q <= tmo_cnt_q + 13'h0001;
      end
    end
  end

  // Call stack depth tracking.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      depth_q <= 9'h000;
    end else if (ce_in) begin
      if (stack_push_in && !stack_pop_in && depth_q != `MFM_STACK_MAX) begin
        depth_q <= depth_q + 9'h001;
      end else if (stack_pop_in && !stack_push_in && depth_q != 9'h000) begin
        depth_q <= depth_q - 9'h001;
      end
    end
  end

  // End stop hits collected during one homing run.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hit_a_q <= 1'b0;
      hit_b_q <= 1'b0;
    end else if (ce_in) begin
      if (home_mode == MFM_HOME_IDLE || homing_done_in) begin
        hit_a_q <= 1'b0;
        hit_b_q <= 1'b0;
      end else begin
        if ($signed(actual_position_in) <= $signed(end_a_q)) begin
          hit_a_q <= 1'b1;
        end
        if ($signed(actual_position_in) >= $signed(end_b_q)) begin
          hit_b_q <= 1'b1;
        end
      end
    end
  end

  // Fault events, one bit per fault code.
  always_comb begin
    ev = 16'h0000;
    ev[0] = seq_exec_in && (seq_line_in > `MFM_SEQ_LINE_MAX);
    ev[1] = reg_access_in && (reg_index_in > reg_index_max_in);
    ev[2] = stack_push_in && !stack_pop_in && (depth_q == `MFM_STACK_MAX);
    ev[3] = chk_a_q > `MFM_CHKA_MAX;
    ev[4] = chk_b_q > `MFM_CHKB_MAX;
    ev[5] = axis_cmd_in && !axis_present_in[axis_num_in];
    ev[6] = chain_init_fail_in && (role_q == `MFM_ROLE_MASTER);
    ev[7] = mon_opt_q[`MFM_B_CHAIN_TMO] && (tmo_cnt_q == 13'(`MFM_CHAIN_TMO_CYC));
    ev[8] = chain_dup_node_in;
    ev[9] = (home_mode != MFM_HOME_IDLE) && switch_active_in && (leave_travel_in >= leave_q);
    ev[10] = (home_mode == MFM_HOME_MULTI) && hit_a_q && hit_b_q && !homing_done_in;
    ev[11] = (home_mode == MFM_HOME_SINGLE) && hit_a_q && hit_b_q && !homing_done_in;
    ev[12] = sync_start_fail_in;
    ev[13] = st_chk_q[`MFM_B_STROKE_ACT] && out_of(actual_position_in, st_lo_q, st_hi_q);
    ev[14] = st_chk_q[`MFM_B_STROKE_REF] && out_of(ref_position_in, st_lo_q, st_hi_q);
  end

  // Lowest event index has priority.
  always_comb begin
    pick = 4'hF;
    for (int i = 14; i >= 0; i--) begin
      if (ev[i]) begin
        pick = 4'(i);
      end
    end
  end

  assign sw_rst = req.wr && (req.addr == `MFM_A_CTRL) && req.wdata[`MFM_B_SWRST];
  assign load = (|ev) && (!latched_q || (hw_only(pick) && !hw_q));

  // Fault latch: software reset clears only clearable faults; a hardware-reset-only fault, or any fault while none is latched, wins over the clear.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      latched_q <= 1'b0;
      hw_q <= 1'b0;
      code_q <= 8'h00;
    end else if (ce_in) begin
      if (sw_rst && !hw_q) begin
        latched_q <= 1'b0;
        code_q <= 8'h00;
      end
      if (load) begin
        latched_q <= 1'b1;
        hw_q <= hw_only(pick);
        code_q <= code_of(pick);
      end
    end
  end

  // History write pointer advances on each new latched fault.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hist_wp_q <= 4'h0;
    end else if (ce_in && load) begin
      hist_wp_q <= hist_wp_q + 4'h1;
    end
  end

  mfm_hist_mem u_hist (
    .clock_in(clock_in),
    .ce_in(ce_in),
    .wr_in(load),
    .waddr_in(hist_wp_q),
    .wdata_in(code_of(pick)),
    .raddr_in(hist_sel_q),
    .rdata_out(hist_rd)
  );

  // Sticky status: set wins over a clear in the same cycle.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      status_q <= 16'h0000;
    end else if (ce_in) begin
      if (req.wr && req.addr == `MFM_A_ICLR) begin
        status_q <= (status_q & ~req.wdata[15:0]) | ev;
      end else begin
        status_q <= status_q | ev;
      end
    end
  end

  // Software-written configuration registers.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_en_q <= 16'h0000;
      chk_a_q <= `MFM_RST_ZERO;
      chk_b_q <= `MFM_RST_ZERO;
      mon_opt_q <= `MFM_RST_ZERO;
      role_q <= `MFM_RST_ZERO;
      leave_q <= `MFM_RST_ZERO;
      end_a_q <= `MFM_RST_ZERO;
      end_b_q <= `MFM_RST_ZERO;
      st_lo_q <= `MFM_RST_ZERO;
      st_hi_q <= `MFM_RST_ZERO;
      st_chk_q <= `MFM_RST_ZERO;
      sync_q <= `MFM_RST_ZERO;
      hist_sel_q <= 4'h0;
    end else if (ce_in && req.wr) begin
      case (req.addr)
        `MFM_A_IEN: irq_en_q <= req.wdata[15:0];
        `MFM_A_CHKA: chk_a_q <= req.wdata;
        `MFM_A_CHKB: chk_b_q <= req.wdata;
        `MFM_A_MOPT: mon_opt_q <= req.wdata;
        `MFM_A_ROLE: role_q <= req.wdata;
        `MFM_A_LEAVE: leave_q <= req.wdata;
        `MFM_A_ENDA: end_a_q <= req.wdata;
        `MFM_A_ENDB: end_b_q <= req.wdata;
        `MFM_A_STLO: st_lo_q <= req.wdata;
        `MFM_A_STHI: st_hi_q <= req.wdata;
        `MFM_A_STCHK: st_chk_q <= req.wdata;
        `MFM_A_SYNC: sync_q <= req.wdata;
        `MFM_A_HSEL: hist_sel_q <= req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // Read data register, valid in the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce_in) begin
      rdata_q <= 32'h0000_0000;
      if (req.rd) begin
        case (req.addr)
          `MFM_A_CODE: rdata_q <= {22'h000000, hw_q, latched_q, code_q};
          `MFM_A_STAT: rdata_q <= {16'h0000, status_q};
          `MFM_A_IEN: rdata_q <= {16'h0000, irq_en_q};
          `MFM_A_CHKA: rdata_q <= chk_a_q;
          `MFM_A_CHKB: rdata_q <= chk_b_q;
          `MFM_A_MOPT: rdata_q <= mon_opt_q;
          `MFM_A_ROLE: rdata_q <= role_q;
          `MFM_A_LEAVE: rdata_q <= leave_q;
          `MFM_A_ENDA: rdata_q <= end_a_q;
          `MFM_A_ENDB: rdata_q <= end_b_q;
          `MFM_A_STLO: rdata_q <= st_lo_q;
          `MFM_A_STHI: rdata_q <= st_hi_q;
          `MFM_A_STCHK: rdata_q <= st_chk_q;
          `MFM_A_SYNC: rdata_q <= sync_q;
          `MFM_A_HSEL: rdata_q <= {28'h0000000, hist_sel_q};
          `MFM_A_HDAT: rdata_q <= {24'h000000, hist_rd};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Interrupt level and fault outputs, each from a flip-flop.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= |(status_q & irq_en_q);
    end
  end
  assign rdata_out = rdata_q;
  assign fault_code_out = code_q;
  assign fault_active_out = latched_q;

  // Checks.
  sequence s_seq_bad;
    ce_in && seq_exec_in && (seq_line_in > `MFM_SEQ_LINE_MAX) && !latched_q;
  endsequence
  sequence s_stack_full;
    ce_in && (depth_q == `MFM_STACK_MAX) && stack_push_in && !stack_pop_in;
  endsequence

  a_seq_line_code: assert property (@(posedge clock_in) disable iff (rst_in)
    s_seq_bad |=> (code_q == 8'h25) && latched_q) else $error("fault 37 not latched");
  a_stack_ovf_hw: assert property (@(posedge clock_in) disable iff (rst_in)
    s_stack_full ##0 !hw_q |=> hw_q && (code_q == 8'h27)) else $error("fault 39 not latched");
  a_hw_fault_holds: assert property (@(posedge clock_in) disable iff (rst_in)
    hw_q |=> hw_q && latched_q && $stable(code_q)) else $error("hardware fault lost");
  a_sw_clear_works: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && sw_rst && latched_q && !hw_q && !(|ev) |=> !latched_q) else $error("software reset ignored");
  a_code_held: assert property (@(posedge clock_in) disable iff (rst_in)
    latched_q && !sw_rst && !(|ev) |=> $stable(code_q)) else $error("fault code changed");
  a_chain_tmo_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    ev[7] |-> mon_opt_q[`MFM_B_CHAIN_TMO] && chain_armed_q) else $error("timeout fault while disabled");
  a_stroke_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && ev[13] |=> status_q[13] [*2]) else $error("stroke status not sticky");
  a_irq_follows: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && |(status_q & irq_en_q) |=> irq_out) else $error("interrupt not raised");
  a_dup_node_code: assert property (@(posedge clock_in) disable iff (rst_in)
    ce_in && chain_dup_node_in && !latched_q && !(|ev[7:0]) |=> code_q == 8'h3B) else $error("fault 59 wrong");

endmodule

// ===== mfm_chain_node.sv
// Purpose: Model of the chain bus nodes on the far side of the fault monitor.
// Assumes: A command is one level change of the command pin.
// Notes: The pin stands still while traffic is off, as a silent chain would.
`timescale 1ns/1ps
module mfm_chain_node (
  input wire logic clock_in,
  input wire logic run_in,
  input wire logic dup_in,
  output logic cmd_pin_out,
  output logic dup_node_out
);
  int cnt_q;

  // Starts with a quiet pin and a cleared command counter.
  initial begin
    cmd_pin_out = 1'b0;
    cnt_q = 0;
  end

  // Sends one command every eight cycles while traffic runs, and holds the pin otherwise.
  always @(posedge clock_in) begin
    if (run_in) begin
      cnt_q <= cnt_q + 1;
      if (cnt_q % 8 == 7) begin
        cmd_pin_out <= ~cmd_pin_out;
      end
    end
  end

  // Reports a second node that answers to the same node number.
  assign dup_node_out = dup_in;
endmodule

// ===== test_motion_fault_monitor.sv
// Purpose: Self-checking bench of the motion fault monitor.
// Assumes: One 40 MHz clock; the chain node model drives the command pin.
// Notes: Each fault row is followed by a hardware reset so rows stay independent.
`include "mfm_defs.svh"
`timescale 1ns/1ps
module test_motion_fault_monitor;
  import mfm_pkg::*;
  typedef struct {int ev; logic [7:0] code; logic hw; int lat;} mfm_row_t;
  logic clock_in, rst_in, wr, rd, sexe, racc, push, pop, acmd, ifail, sw, sfail, run, dup, pin, dupn;
  logic irq_out, fault_active_out, ce, done;
  logic [1:0] hmode;
  logic [3:0] anum;
  logic [7:0] addr, fault_code_out;
  logic [15:0] sline, ridx, rmax, apres;
  logic [31:0] wdata, rdata_out, ltr, apos, rpos, d;
  mfm_row_t rows [15];
  int checks, bad_count, cyc, n;

  mfm_monitor u_dut (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out), .irq_out(irq_out), .fault_code_out(fault_code_out),
    .fault_active_out(fault_active_out), .seq_exec_in(sexe), .seq_line_in(sline), .reg_access_in(racc),
    .reg_index_in(ridx), .reg_index_max_in(rmax), .stack_push_in(push), .stack_pop_in(pop),
    .axis_cmd_in(acmd), .axis_num_in(anum), .axis_present_in(apres), .chain_init_fail_in(ifail),
    .chain_cmd_pin_in(pin), .chain_dup_node_in(dupn), .homing_mode_in(hmode), .homing_done_in(done),
    .leave_travel_in(ltr), .switch_active_in(sw), .sync_start_fail_in(sfail),
    .actual_position_in(apos), .ref_position_in(rpos));

  mfm_chain_node u_node (.clock_in(clock_in), .run_in(run), .dup_in(dup), .cmd_pin_out(pin),
    .dup_node_out(dupn));

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock_in);
  endtask

  // One-cycle register write.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    step(1);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    step(1);
    wr <= 1'b0;
  endtask

  // One-cycle register read; data are taken in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    step(1);
    addr <= a;
    rd <= 1'b1;
    step(1);
    rd <= 1'b0;
    #1 v = rdata_out;
  endtask

  // Returns level inputs to idle and pulses the hardware reset.
  task automatic hw_reset;
    step(1);
    {hmode, sw, run, dup} <= '0;
    {ltr, apos, rpos} <= '0;
    rst_in <= 1'b1;
    step(2);
    rst_in <= 1'b0;
    step(1);
  endtask

  // Waits a bounded number of cycles for a latched fault.
  task automatic wait_fault(input int lim);
    n = 0;
    #1;
    while (fault_active_out !== 1'b1 && n < lim) begin
      step(1);
      #1 n++;
    end
    cmp("fault latched", 32'h1, {31'h0, fault_active_out});
  endtask

  // Creates the condition of one fault event.
  task automatic fire(input int ev);
    step(1);
    case (ev)
      0: begin sline <= 16'h1FFF; sexe <= 1'b1; step(1); sexe <= 1'b0; end
      1: begin ridx <= 16'h0005; rmax <= 16'h0004; racc <= 1'b1; step(1); racc <= 1'b0; end
      2: begin
        push <= 1'b1;
        step(256);
        push <= 1'b0;
        pop <= 1'b1;
        step(1);
        pop <= 1'b0;
        push <= 1'b1;
        step(1);
        push <= 1'b0;
        step(1);
        #1 cmp("depth 256", 32'h0, {31'h0, fault_active_out});
        push <= 1'b1;
        step(1);
        push <= 1'b0;
      end
      3: wr_reg(`MFM_A_CHKA, 32'h0000_0100);
      4: wr_reg(`MFM_A_CHKB, 32'h0000_0100);
      5: begin apres <= 16'hFFF7; anum <= 4'h3; acmd <= 1'b1; step(1); acmd <= 1'b0; end
      6: begin wr_reg(`MFM_A_ROLE, 32'h1); ifail <= 1'b1; step(1); ifail <= 1'b0; end
      7: begin
        wr_reg(`MFM_A_MOPT, 32'h2);
        run <= 1'b1;
        step(100);
        #1 cmp("chain traffic", 32'h0, {31'h0, fault_active_out});
        run <= 1'b0;
      end
      8: begin dup <= 1'b1; step(1); dup <= 1'b0; end
      9: begin
        wr_reg(`MFM_A_ENDA, 32'hFFFF_FC18);
        wr_reg(`MFM_A_ENDB, 32'h0000_03E8);
        wr_reg(`MFM_A_LEAVE, 32'h0000_000A);
        hmode <= MFM_HOME_MULTI;
        ltr <= 32'h0000_000A;
        sw <= 1'b1;
        step(1);
      end
      10, 11: begin
        wr_reg(`MFM_A_ENDA, 32'hFFFF_FF9C);
        wr_reg(`MFM_A_ENDB, 32'h0000_0064);
        hmode <= (ev == 10) ? MFM_HOME_MULTI : MFM_HOME_SINGLE;
        apos <= 32'hFFFF_FF9C;
        step(1);
        apos <= 32'h0000_0064;
        step(1);
      end
      12: begin sfail <= 1'b1; step(1); sfail <= 1'b0; end
      default: begin
        wr_reg(`MFM_A_STLO, 32'hFFFF_FFCE);
        wr_reg(`MFM_A_STHI, 32'h0000_0032);
        wr_reg(`MFM_A_STCHK, (ev == 13) ? 32'h2 : 32'h4);
        if (ev == 13) apos <= 32'h0000_003C;
        else rpos <= 32'h0000_003C;
      end
    endcase
  endtask

  // Makes the 40 MHz clock.
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Cuts a hung run short.
  always @(posedge clock_in) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      results();
    end
  end

  // Main sequence: reset checks, the fault table, then the awkward cases.
  initial begin
    {rst_in, wr, rd, sexe, racc, push, pop, acmd, ifail, sw, sfail, run, dup} = 13'h1000;
    {hmode, anum, addr, sline, ridx, rmax, apres, wdata, ltr, apos, rpos} = '0;
    {ce, done} = 2'b10;
    rows[0] = '{0, 8'h25, 1'b0, 0};
    rows[1] = '{1, 8'h26, 1'b0, 0};
    rows[2] = '{2, 8'h27, 1'b1, 0};
    rows[3] = '{3, 8'h28, 1'b1, 2};
    rows[4] = '{4, 8'h29, 1'b1, 2};
    rows[5] = '{5, 8'h34, 1'b0, 0};
    rows[6] = '{6, 8'h36, 1'b0, 0};
    rows[7] = '{7, 8'h38, 1'b0, 4100};
    rows[8] = '{8, 8'h3B, 1'b1, 0};
    rows[9] = '{9, 8'h3C, 1'b0, 1};
    rows[10] = '{10, 8'h3D, 1'b0, 2};
    rows[11] = '{11, 8'h3E, 1'b0, 2};
    rows[12] = '{12, 8'h3F, 1'b0, 0};
    rows[13] = '{13, 8'h41, 1'b0, 2};
    rows[14] = '{14, 8'h42, 1'b0, 2};
    step(4);
    rst_in <= 1'b0;
    step(1);
    #1 cmp("outputs after reset", 32'h0, {22'h0, irq_out, fault_active_out, fault_code_out});
    wr_reg(`MFM_A_CODE, 32'h0000_00FF);
    rd_reg(`MFM_A_CODE, d);
    cmp("code read-only", 32'h0, d);
    rd_reg(8'hFC, d);
    cmp("unmapped read", 32'h0, d);
    foreach (rows[i]) begin
      fire(rows[i].ev);
      wait_fault(rows[i].lat);
      cmp("fault code", {24'h0, rows[i].code}, {24'h0, fault_code_out});
      rd_reg(`MFM_A_STAT, d);
      cmp("status bit", 32'h1, {31'h0, d[rows[i].ev]});
      rd_reg(`MFM_A_CODE, d);
      cmp("hw-only flag", {31'h0, rows[i].hw}, {31'h0, d[9]});
      hw_reset();
      #1 cmp("hw reset clears", 32'h0, {24'h0, fault_code_out});
    end
    // Boundary values and disabled checks must not raise a fault.
    step(1);
    sline <= 16'h1FFE;
    sexe <= 1'b1;
    ridx <= 16'h0004;
    rmax <= 16'h0004;
    racc <= 1'b1;
    ifail <= 1'b1;
    apos <= 32'h0000_003C;
    step(1);
    {sexe, racc, ifail} <= 3'h0;
    step(2);
    #1 cmp("no fault at limits", 32'h0, {31'h0, fault_active_out});
    hw_reset();
    fire(0);
    wr_reg(`MFM_A_CTRL, 32'h1);
    #1 cmp("sw reset clears", 32'h0, {31'h0, fault_active_out});
    fire(0);
    fire(3);
    wait_fault(2);
    step(2);
    wr_reg(`MFM_A_CTRL, 32'h1);
    step(1);
    #1 cmp("hw-only holds", 32'h28, {24'h0, fault_code_out});
    hw_reset();
    wr_reg(`MFM_A_IEN, 32'h2);
    fire(0);
    step(2);
    #1 cmp("irq masked", 32'h0, {31'h0, irq_out});
    wr_reg(`MFM_A_IEN, 32'h1);
    step(1);
    #1 cmp("irq raised", 32'h1, {31'h0, irq_out});
    wr_reg(`MFM_A_ICLR, 32'h1);
    step(1);
    #1 cmp("irq cleared", 32'h0, {31'h0, irq_out});
    rd_reg(`MFM_A_STAT, d);
    cmp("status cleared", 32'h0, d);
    // The first entry of the history holds the code latched since the last hardware reset.
    wr_reg(`MFM_A_HSEL, 32'h0);
    step(1);
    rd_reg(`MFM_A_HDAT, d);
    cmp("history entry", 32'h25, d);
    // A low clock enable freezes the monitor, so a pulse in that cycle is missed.
    hw_reset();
    ce <= 1'b0;
    fire(0);
    ce <= 1'b1;
    step(1);
    #1 cmp("ce freeze", 32'h0, {31'h0, fault_active_out});
    // Both end stops reached after homing has finished must not raise a fault.
    done <= 1'b1;
    fire(10);
    step(2);
    #1 cmp("homing done", 32'h0, {31'h0, fault_active_out});
    done <= 1'b0;
    results();
  end
endmodule
